// file: fws_pkg.sv
// Package of constants and types for the flash write status poller
package fws_pkg;
    // Flash data bus bit positions
    localparam int DATA_POLL_BIT = 7;
    localparam int GLOBAL_TOGGLE_BIT = 6;
    localparam int TIMEOUT_BIT = 5;
    localparam int WINDOW_BIT = 3;
    localparam int SECTOR_TOGGLE_BIT = 2;
    localparam int ADDR_W = 18;
    localparam int DATA_W = 16;
    // Read bus timing, in ns and core cycles at 25 ns
    localparam int CLK_PERIOD_NS = 25;
    localparam int READ_ACCESS_NS = 70;
    localparam int READ_CYCLES = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVER_NS = 25;
    localparam int RECOVER_CYCLES = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] CNT_RESET = 4'h0;
    localparam logic [DATA_W-1:0] RESET_CMD = 16'h00F0;

    typedef enum {FWS_IDLE, FWS_RD_ASSERT, FWS_RD_HOLD, FWS_RD_GAP, FWS_EVAL,
                  FWS_RESET_WR, FWS_RESET_GAP} fws_state_t;

    typedef enum logic [2:0] {
        FWS_RES_NONE = 3'h0,
        FWS_RES_DONE = 3'h1,
        FWS_RES_FAIL = 3'h2,
        FWS_RES_BUSY = 3'h3
    } fws_result_t;

    // Pins toward the flash
    typedef struct packed {
        logic chipEnN;
        logic outEnN;
        logic writeEnN;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dataOut;
        logic dataOe;
    } fws_pins_t;

    // Answer to the user
    typedef struct packed {
        logic done;
        fws_result_t result;
        logic windowOpen;
        logic readyBusy;
        logic [DATA_W-1:0] status;
    } fws_answer_t;

    typedef struct packed {
        fws_state_t state;
        logic [3:0] cnt;
        logic [1:0] readIdx;
        logic recheck;
        logic [DATA_W-1:0] first;
        logic [DATA_W-1:0] second;
        logic [ADDR_W-1:0] addr;
        fws_pins_t pins;
        fws_answer_t ans;
    } fws_regs_t;
endpackage : fws_pkg

// file: fws_poller.sv
// Host-side toggle-bit poller driving the flash control pins
`timescale 1ns/1ps
module fws_poller (
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic clkEn,
    // User request
    input wire logic pollStart,
    input wire logic [fws_pkg::ADDR_W-1:0] pollAddr,
    // Flash pins
    input wire logic [fws_pkg::DATA_W-1:0] flashDataIn,
    input wire logic readyBusyNIn,
    output fws_pkg::fws_pins_t flashPins,
    // User answer
    output fws_pkg::fws_answer_t pollAnswer
);
    import fws_pkg::*;

    fws_regs_t cur_ff;
    fws_regs_t nxt_cur;
    logic toggled;

    always_comb
    begin
        // Only toggle bit compared; the sector bit is user-visible via status
        toggled = cur_ff.first[GLOBAL_TOGGLE_BIT] != cur_ff.second[GLOBAL_TOGGLE_BIT];
        nxt_cur = cur_ff;
        nxt_cur.ans.done = 1'b0;
        nxt_cur.ans.readyBusy = readyBusyNIn;
        unique case (cur_ff.state)
            FWS_IDLE:
            begin
                if (pollStart)
                begin
                    // Every poll restarts from the first double read
                    nxt_cur.addr = pollAddr;
                    nxt_cur.readIdx = 2'h0;
                    nxt_cur.recheck = 1'b0;
                    nxt_cur.state = FWS_RD_ASSERT;
                end
            end
            FWS_RD_ASSERT:
            begin
                nxt_cur.pins.addr = cur_ff.addr;
                nxt_cur.pins.chipEnN = 1'b0;
                nxt_cur.pins.outEnN = 1'b0;
                nxt_cur.pins.dataOe = 1'b0;
                nxt_cur.cnt = CNT_RESET;
                nxt_cur.state = FWS_RD_HOLD;
            end
            FWS_RD_HOLD:
            begin
                nxt_cur.cnt = cur_ff.cnt + 4'h1;
                if (cur_ff.cnt == 4'(READ_CYCLES - 1))
                begin
                    if (cur_ff.readIdx == 2'h0)
                        nxt_cur.first = flashDataIn;
                    else
                        nxt_cur.second = flashDataIn;
                    // Raising both ends the read cycle
                    nxt_cur.pins.chipEnN = 1'b1;
                    nxt_cur.pins.outEnN = 1'b1;
                    nxt_cur.cnt = CNT_RESET;
                    nxt_cur.state = FWS_RD_GAP;
                end
            end
            FWS_RD_GAP:
            begin
                nxt_cur.cnt = cur_ff.cnt + 4'h1;
                if (cur_ff.cnt == 4'(RECOVER_CYCLES - 1))
                begin
                    nxt_cur.readIdx = cur_ff.readIdx + 2'h1;
                    nxt_cur.state = (cur_ff.readIdx == 2'h0) ? FWS_RD_ASSERT : FWS_EVAL;
                end
            end
            FWS_EVAL:
            begin
                nxt_cur.ans.status = cur_ff.second;
                nxt_cur.ans.windowOpen = ~cur_ff.second[WINDOW_BIT];
                if (!toggled)
                begin
                    nxt_cur.ans.result = FWS_RES_DONE;
                    nxt_cur.ans.done = 1'b1;
                    nxt_cur.state = FWS_IDLE;
                end
                else if (cur_ff.second[TIMEOUT_BIT] && !cur_ff.recheck)
                begin
                    // Toggle may stop as the timeout flag rises
                    nxt_cur.recheck = 1'b1;
                    nxt_cur.first = cur_ff.second;
                    nxt_cur.readIdx = 2'h1;
                    nxt_cur.state = FWS_RD_ASSERT;
                end
                else if (cur_ff.recheck)
                begin
                    nxt_cur.ans.result = FWS_RES_FAIL;
                    nxt_cur.state = FWS_RESET_WR;
                end
                else
                begin
                    nxt_cur.ans.result = FWS_RES_BUSY;
                    nxt_cur.ans.done = 1'b1;
                    nxt_cur.state = FWS_IDLE;
                end
            end
            FWS_RESET_WR:
            begin
                nxt_cur.pins.chipEnN = 1'b0;
                nxt_cur.pins.writeEnN = 1'b0;
                nxt_cur.pins.dataOut = RESET_CMD;
                nxt_cur.pins.dataOe = 1'b1;
                nxt_cur.cnt = cur_ff.cnt + 4'h1;
                if (cur_ff.cnt == 4'(READ_CYCLES - 1))
                begin
                    nxt_cur.pins.writeEnN = 1'b1;
                    nxt_cur.pins.chipEnN = 1'b1;
                    nxt_cur.cnt = CNT_RESET;
                    nxt_cur.state = FWS_RESET_GAP;
                end
            end
            FWS_RESET_GAP:
            begin
                nxt_cur.pins.dataOe = 1'b0;
                nxt_cur.ans.done = 1'b1;
                nxt_cur.state = FWS_IDLE;
            end
        endcase
        if (cur_ff.state == FWS_EVAL && cur_ff.recheck && toggled)
            nxt_cur.cnt = CNT_RESET;
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cur_ff <= '{state: FWS_IDLE, cnt: CNT_RESET, readIdx: 2'h0, recheck: 1'b0,
                       first: '0, second: '0, addr: '0,
                       pins: '{chipEnN: 1'b1, outEnN: 1'b1, writeEnN: 1'b1, addr: '0,
                               dataOut: '0, dataOe: 1'b0},
                       ans: '{done: 1'b0, result: FWS_RES_NONE, windowOpen: 1'b0,
                              readyBusy: 1'b1, status: '0}};
        end
        else if (clkEn)
        begin
            cur_ff <= nxt_cur;
        end
    end

    assign flashPins = cur_ff.pins;
    assign pollAnswer = cur_ff.ans;

    fail_resets_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        clkEn && cur_ff.state == FWS_EVAL && cur_ff.recheck && toggled |=> cur_ff.state == FWS_RESET_WR)
        else $error("failed poll did not issue reset");
    done_steady_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        pollAnswer.done && pollAnswer.result == FWS_RES_DONE |->
        $past(cur_ff.first[GLOBAL_TOGGLE_BIT], 2) == $past(cur_ff.second[GLOBAL_TOGGLE_BIT], 2)
        || !$past(clkEn))
        else $error("done reported with toggling bit");

    // Toggle still running with the timeout flag up earns exactly one more read
    sequence toggleWithTimeout;
        clkEn && cur_ff.state == FWS_EVAL && toggled && cur_ff.second[TIMEOUT_BIT]
            && !cur_ff.recheck;
    endsequence

    sequence recheckReadStarts;
        cur_ff.state == FWS_RD_ASSERT && cur_ff.recheck && cur_ff.readIdx == 2'h1;
    endsequence

    recheck_read_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        toggleWithTimeout |=> recheckReadStarts)
        else $error("timeout with toggling did not recheck");

    // Between polls the shared bus must be left alone
    idle_released_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        cur_ff.state == FWS_IDLE |-> flashPins.chipEnN && flashPins.outEnN
            && flashPins.writeEnN && !flashPins.dataOe)
        else $error("bus not released while idle");

    // Sector status bits are only meaningful at the polled address
    addr_steady_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        !flashPins.outEnN |-> !flashPins.chipEnN && !flashPins.dataOe
            && flashPins.addr == cur_ff.addr)
        else $error("read cycle without the polled address");

    sequence resetWordDriven;
        flashPins.dataOe && !flashPins.chipEnN && flashPins.outEnN
            && flashPins.dataOut == RESET_CMD;
    endsequence

    reset_write_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        !flashPins.writeEnN |-> resetWordDriven)
        else $error("write strobe without the reset command");

    // The failure is only reported once the reset command has gone out
    sequence resetWriteEnding;
        clkEn && cur_ff.state == FWS_RESET_GAP;
    endsequence

    fail_report_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        resetWriteEnding |=> pollAnswer.done && pollAnswer.result == FWS_RES_FAIL)
        else $error("reset write not followed by failure report");

    window_report_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        pollAnswer.done |-> pollAnswer.windowOpen == !pollAnswer.status[WINDOW_BIT])
        else $error("window report disagrees with status");
endmodule : fws_poller

// file: fws_flash_model.sv
// Behavioural flash device answering the poller's status reads
`timescale 1ns/1ps
module fws_flash_model
    import fws_pkg::*;
#(
    parameter logic [DATA_W-1:0] ARRAY_WORD = 16'h005A
) (
    // Pins from the host
    input wire fws_pkg::fws_pins_t pins,
    // Scenario controls
    input wire logic runOp,
    input wire logic failOp,
    // Device outputs
    output logic [fws_pkg::DATA_W-1:0] dataOut,
    output logic busyPullLow
);
    logic aborted = 1'b0;
    logic tog = 1'b0;
    logic [DATA_W-1:0] last = 16'h0000;
    logic [DATA_W-1:0] word;
    wire logic active = runOp && !aborted;
    wire logic readEnd = pins.chipEnN | pins.outEnN;
    // A write ends on whichever of chip enable or write enable rises first
    wire logic writeEnd = pins.chipEnN | pins.writeEnN;
    // Only pulls low; the high level comes from the shared pull-up
    assign busyPullLow = active;
    // Timeout bit stands for a halted program of a one over a zero
    assign word = active ? {8'h00, 1'b0, tog, failOp, 1'b0, 1'b1, tog, 2'b00} : ARRAY_WORD;
    // A released bus shows no stale value
    assign dataOut = readEnd ? ~last : word;
    always @(posedge readEnd)
    begin
        last <= word;
        // Toggling stops as soon as the operation ends
        if (active) tog <= !tog;
    end
    // Chip and write enable rise together, so the write end is taken from both
    always @(posedge writeEnd or negedge runOp)
    begin
        if (!runOp)
            aborted <= 1'b0;
        else if (pins.dataOe && pins.dataOut[7:0] == 8'hF0)
            aborted <= 1'b1;
    end
endmodule : fws_flash_model

// file: fws_poller_tb.sv
// Self-checking bench for the toggle-bit poller
`timescale 1ns/1ps
module fws_poller_tb;
    import fws_pkg::*;
    localparam logic [DATA_W-1:0] ARRAY_WORD = 16'h005A;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic pollStart = 1'b0;
    logic [ADDR_W-1:0] pollAddr = 18'h00000;
    logic runOp = 1'b0;
    logic failOp = 1'b0;
    logic [DATA_W-1:0] flashData;
    logic busyPullLow;
    fws_pins_t flashPins;
    fws_answer_t pollAnswer;
    int fails = 0;
    int samples_checked = 0;
    wire logic readyBusyN = busyPullLow ? 1'b0 : 1'b1;
    always #12.5 core_clk = ~core_clk;
    fws_poller fws_poller_i (.core_clk(core_clk), .arst_n(arst_n), .clkEn(1'b1),
        .pollStart(pollStart), .pollAddr(pollAddr), .flashDataIn(flashData),
        .readyBusyNIn(readyBusyN), .flashPins(flashPins), .pollAnswer(pollAnswer));
    fws_flash_model #(.ARRAY_WORD(ARRAY_WORD)) fws_flash_model_i (.pins(flashPins),
        .runOp(runOp), .failOp(failOp), .dataOut(flashData), .busyPullLow(busyPullLow));
    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : give_verdict
    // Starts a poll and waits for its answer under a bound
    task automatic poll(input logic [ADDR_W-1:0] where);
        int n;
        n = 0;
        pollAddr = where;
        pollStart = 1'b1;
        @(posedge core_clk) #2;
        pollStart = 1'b0;
        while (pollAnswer.done !== 1'b1 && n < 80)
        begin
            @(posedge core_clk) #2;
            n++;
        end
        if (n >= 80)
        begin
            fails++;
            give_verdict();
        end
    endtask : poll
    task automatic finished_op;
        poll(18'h00010);
        check(16'(pollAnswer.result), 16'(FWS_RES_DONE));
        check(pollAnswer.status, ARRAY_WORD);
        check(16'(pollAnswer.readyBusy), 16'h0001);
    endtask : finished_op
    task automatic running_op;
        runOp = 1'b1;
        repeat (3) @(posedge core_clk) #2;
        poll(18'h10000);
        check(16'(pollAnswer.result), 16'(FWS_RES_BUSY));
        check(16'(pollAnswer.readyBusy), 16'h0000);
        check(16'(pollAnswer.windowOpen), 16'h0000);
        check(16'(pollAnswer.status[DATA_POLL_BIT]), 16'h0000);
    endtask : running_op
    // Back-to-back polls: the failing one must leave the device in read mode
    task automatic failed_op;
        failOp = 1'b1;
        poll(18'h10000);
        check(16'(pollAnswer.result), 16'(FWS_RES_FAIL));
        check(16'(pollAnswer.status[TIMEOUT_BIT]), 16'h0001);
        failOp = 1'b0;
        poll(18'h10000);
        check(16'(pollAnswer.result), 16'(FWS_RES_DONE));
        check(pollAnswer.status, ARRAY_WORD);
        runOp = 1'b0;
    endtask : failed_op
    initial
    begin
        repeat (2) @(posedge core_clk);
        #2 arst_n = 1'b1;
        finished_op();
        running_op();
        failed_op();
        give_verdict();
    end
endmodule : fws_poller_tb
